/* secp_core.sv */
`timescale 1ns/1ps
// Command queue between serial front end and programming engine
module secp_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];   // Storage
    logic [PW:0]      wp_ff;           // Write pointer, wrap bit on top
    logic [PW:0]      rp_ff;           // Read pointer

    // Full and empty from pointer compare
    assign in_ready  = !((wp_ff[PW] != rp_ff[PW]) && (wp_ff[PW-1:0] == rp_ff[PW-1:0]));
    assign out_valid = (wp_ff != rp_ff);
    assign out_data  = mem_q[rp_ff[PW-1:0]];

    // Pointer and storage update
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (in_valid && in_ready) begin
                mem_q[wp_ff[PW-1:0]] <= in_data;
                wp_ff <= wp_ff + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end
endmodule

// Serial command port of the nonvolatile array
module secp_core #(
    parameter int unsigned PROG_CYCLES = secp_pkg::PROG_CYC
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Serial pins, asynchronous to ref_clk
    input  wire logic chip_sel,
    input  wire logic ser_clk,
    input  wire logic serial_data_in,
    input  wire logic organization_select,
    // Serial output pin
    output logic      serial_data_out,
    output logic      serial_data_out_en,
    // Status
    output logic      prog_busy,
    output logic      write_enable_on
);
    // All state of the block except the array and the command queue
    typedef struct packed {
        logic [3:0]          s1;       // Synchroniser first stage
        logic [3:0]          s2;       // Synchroniser second stage
        logic                sclk_d;   // Previous serial clock
        logic                cs_d;     // Previous select
        secp_pkg::secp_st_t  st;       // Front-end state
        logic                word;     // Organization of this frame
        logic [1:0]          opc;      // Opcode
        logic [4:0]          cnt;      // Bit counter
        logic [6:0]          addr;     // Address / read pointer
        logic [15:0]         sh;       // Input data shift
        logic [15:0]         osh;      // Output data shift
        logic [4:0]          ocnt;     // Output bits left
        logic                sdo;      // Data out level
        logic                doe;      // Data out enable
        logic                wen;      // Program enable latch
        logic                shown;    // Status display armed
        logic                pend;     // Command awaiting deselect
        secp_pkg::secp_cmd_t pc;       // Pending command
        logic                pbusy;    // Engine running
        logic [18:0]         tmr;      // Programming timer
        secp_pkg::secp_cmd_t ec;       // Command in progress
        logic                busy_o;   // Registered busy
        logic [18:0]         blen;     // Busy length, for the timing check
    } secp_state_t;

    secp_state_t          cur_ff;      // Registered state
    secp_state_t          nxt_cur;     // Next state
    logic [7:0]           mem_q [secp_pkg::MEM_BYTES]; // Array
    logic                 push;        // Queue a command
    logic                 q_rdy;       // Queue has room
    logic                 q_val;       // Queue holds a command
    logic                 pop;         // Engine takes a command
    logic                 done;        // Programming finished
    logic                 en_x;        // Enable executed
    logic                 dis_x;       // Disable executed
    logic                 rd_load;     // Read data first loaded
    secp_pkg::secp_cmd_t  q_out;       // Queue head

    // Synchronised pins and edges
    wire cs_s   = cur_ff.s2[3];
    wire sclk_s = cur_ff.s2[2];
    wire di_s   = cur_ff.s2[1];
    wire org_s  = cur_ff.s2[0];
    wire s_rise = sclk_s && !cur_ff.sclk_d;
    wire cs_rise = cs_s && !cur_ff.cs_d;
    wire cs_fall = !cs_s && cur_ff.cs_d;
    wire busy   = cur_ff.pbusy || q_val;

    // Address width per organization
    function automatic logic [4:0] aw_of(input logic w);
        aw_of = w ? 5'(secp_pkg::WORD_AW) : 5'(secp_pkg::BYTE_AW);
    endfunction

    // Data width per organization
    function automatic logic [4:0] dw_of(input logic w);
        dw_of = w ? 5'(secp_pkg::WORD_DW) : 5'(secp_pkg::BYTE_DW);
    endfunction

    // Fetch a location, MSB aligned to bit 15
    function automatic logic [15:0] rd(input logic w, input logic [6:0] a);
        rd = w ? {mem_q[{a[5:0], 1'b1}], mem_q[{a[5:0], 1'b0}]}
               : {mem_q[a], 8'h00};
    endfunction

    // Next-state logic
    always_comb begin
        nxt_cur = cur_ff;
        push    = 1'b0;
        en_x    = 1'b0;
        dis_x   = 1'b0;
        rd_load = 1'b0;
        pop     = 1'b0;
        done    = 1'b0;
        // Pin synchronisers and edge history
        nxt_cur.s1 = {chip_sel, ser_clk, serial_data_in, organization_select};
        nxt_cur.s2 = cur_ff.s1;
        nxt_cur.sclk_d = sclk_s;
        nxt_cur.cs_d = cs_s;
        if (!cs_s) begin
            // Deselect ends the frame, output released
            nxt_cur.st  = secp_pkg::ST_IDLE;
            nxt_cur.doe = 1'b0;
            nxt_cur.sdo = 1'b0;
            nxt_cur.pend = 1'b0;
            if (cs_fall && cur_ff.pend && cur_ff.wen && q_rdy) begin
                push = 1'b1;
                nxt_cur.shown = 1'b1;
            end
        end else if (cs_rise) begin
            // Arm for a new instruction
            nxt_cur.st = secp_pkg::ST_WAIT;
        end else begin
            unique case (cur_ff.st)
                secp_pkg::ST_IDLE: begin
                    // Select high without a seen rise
                    nxt_cur.st = secp_pkg::ST_IDLE;
                end
                secp_pkg::ST_WAIT: begin
                    // Status shown while waiting
                    nxt_cur.doe = cur_ff.shown;
                    nxt_cur.sdo = !busy;
                    if (s_rise && di_s && !busy) begin
                        // Start bit taken
                        nxt_cur.st    = secp_pkg::ST_OPC;
                        nxt_cur.shown = 1'b0;
                        nxt_cur.doe   = 1'b0;
                        nxt_cur.cnt   = 5'h00;
                        nxt_cur.word  = org_s;
                    end
                end
                secp_pkg::ST_OPC: begin
                    // Two opcode bits
                    if (s_rise) begin
                        nxt_cur.opc = {cur_ff.opc[0], di_s};
                        nxt_cur.cnt = cur_ff.cnt + 5'h01;
                        if (cur_ff.cnt == 5'h01) begin
                            nxt_cur.st  = secp_pkg::ST_ADDR;
                            nxt_cur.cnt = 5'h00;
                        end
                    end
                end
                secp_pkg::ST_ADDR: begin
                    // Address field, width by organization
                    if (s_rise) begin
                        nxt_cur.addr = {cur_ff.addr[5:0], di_s};
                        nxt_cur.cnt  = cur_ff.cnt + 5'h01;
                        if (cur_ff.cnt == aw_of(cur_ff.word) - 5'h01) begin
                            nxt_cur.cnt = 5'h00;
                            nxt_cur.st  = secp_pkg::ST_HOLD;
                            nxt_cur.pc.word = cur_ff.word;
                            nxt_cur.pc.addr = nxt_cur.addr;
                            nxt_cur.pc.data = 16'hffff;
                            unique case (cur_ff.opc)
                                secp_pkg::OP_READ: begin
                                    // Load location, dummy zero first
                                    nxt_cur.st   = secp_pkg::ST_READ;
                                    nxt_cur.osh  = rd(cur_ff.word, nxt_cur.addr);
                                    nxt_cur.ocnt = dw_of(cur_ff.word);
                                    nxt_cur.sdo  = 1'b0;
                                    nxt_cur.doe  = 1'b1;
                                    rd_load      = 1'b1;
                                end
                                secp_pkg::OP_WRITE: begin
                                    nxt_cur.st = secp_pkg::ST_DATA;
                                    nxt_cur.pc.kind = secp_pkg::PK_WRITE;
                                end
                                secp_pkg::OP_ERASE: begin
                                    nxt_cur.pend = 1'b1;
                                    nxt_cur.pc.kind = secp_pkg::PK_ERASE;
                                end
                                default: begin
                                    // Extended group, selected by top bits
                                    unique case (cur_ff.word ? nxt_cur.addr[5:4]
                                                             : nxt_cur.addr[6:5])
                                        secp_pkg::EX_EN: begin
                                            nxt_cur.wen = 1'b1;
                                            en_x = 1'b1;
                                        end
                                        secp_pkg::EX_DIS: begin
                                            nxt_cur.wen = 1'b0;
                                            dis_x = 1'b1;
                                        end
                                        secp_pkg::EX_ERASE_ALL_INSTR: begin
                                            nxt_cur.pend = 1'b1;
                                            nxt_cur.pc.kind = secp_pkg::PK_ERASE_ALL_INSTR;
                                        end
                                        default: begin
                                            nxt_cur.st = secp_pkg::ST_DATA;
                                            nxt_cur.pc.kind = secp_pkg::PK_WRITE_ALL_INSTR;
                                        end
                                    endcase
                                end
                            endcase
                        end
                    end
                end
                secp_pkg::ST_DATA: begin
                    // Write data, MSB first
                    if (s_rise) begin
                        nxt_cur.sh  = {cur_ff.sh[14:0], di_s};
                        nxt_cur.cnt = cur_ff.cnt + 5'h01;
                        if (cur_ff.cnt == dw_of(cur_ff.word) - 5'h01) begin
                            nxt_cur.st   = secp_pkg::ST_HOLD;
                            nxt_cur.pend = 1'b1;
                            nxt_cur.pc.data = nxt_cur.sh;
                        end
                    end
                end
                secp_pkg::ST_READ: begin
                    // Stream bits, reload without dummy
                    if (s_rise) begin
                        nxt_cur.sdo  = cur_ff.osh[15];
                        nxt_cur.osh  = {cur_ff.osh[14:0], 1'b0};
                        nxt_cur.ocnt = cur_ff.ocnt - 5'h01;
                        if (cur_ff.ocnt == 5'h01) begin
                            nxt_cur.addr = cur_ff.word
                                ? {1'b0, cur_ff.addr[5:0] + 6'h01}
                                : cur_ff.addr + 7'h01;
                            nxt_cur.osh  = rd(cur_ff.word, nxt_cur.addr);
                            nxt_cur.ocnt = dw_of(cur_ff.word);
                        end
                    end
                end
                secp_pkg::ST_HOLD: begin
                    // Extra clocks ignored until deselect
                    nxt_cur.st = secp_pkg::ST_HOLD;
                end
                default: begin
                    nxt_cur.st = secp_pkg::ST_IDLE;
                end
            endcase
        end
        // Programming engine on its own timer
        if (!cur_ff.pbusy) begin
            if (q_val) begin
                pop = 1'b1;
                nxt_cur.pbusy = 1'b1;
                nxt_cur.tmr   = 19'h00000;
                nxt_cur.ec    = q_out;
            end
        end else if (32'(cur_ff.tmr) == PROG_CYCLES - 1) begin
            nxt_cur.pbusy = 1'b0;
            done = 1'b1;
        end else begin
            nxt_cur.tmr = cur_ff.tmr + 19'h00001;
        end
        nxt_cur.busy_o = nxt_cur.pbusy || push || (q_val && !pop);
        nxt_cur.blen   = cur_ff.pbusy ? cur_ff.blen + 19'h00001 : 19'h00000;
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Array update at end of programming
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < secp_pkg::MEM_BYTES; i++) begin
                mem_q[i] <= 8'hff;
            end
        end else if (done) begin
            for (int i = 0; i < secp_pkg::MEM_BYTES; i++) begin
                unique case (cur_ff.ec.kind)
                    secp_pkg::PK_ERASE_ALL_INSTR: begin
                        mem_q[i] <= 8'hff;
                    end
                    secp_pkg::PK_WRITE_ALL_INSTR: begin
                        mem_q[i] <= (cur_ff.ec.word && i[0]) ? cur_ff.ec.data[15:8]
                                                             : cur_ff.ec.data[7:0];
                    end
                    secp_pkg::PK_ERASE: begin
                        if (cur_ff.ec.word ? (7'(i >> 1) == {1'b0, cur_ff.ec.addr[5:0]})
                                           : (7'(i) == cur_ff.ec.addr)) begin
                            mem_q[i] <= 8'hff;
                        end
                    end
                    default: begin
                        // Whole location replaced, no prior erase needed
                        if (cur_ff.ec.word && 7'(i >> 1) == {1'b0, cur_ff.ec.addr[5:0]}) begin
                            mem_q[i] <= i[0] ? cur_ff.ec.data[15:8]
                                             : cur_ff.ec.data[7:0];
                        end else if (!cur_ff.ec.word && 7'(i) == cur_ff.ec.addr) begin
                            mem_q[i] <= cur_ff.ec.data[7:0];
                        end
                    end
                endcase
            end
        end
    end

    // Queue of accepted programming commands
    secp_fifo #(
        .WIDTH ($bits(secp_pkg::secp_cmd_t)),
        .DEPTH (secp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (q_rdy),
        .in_data   (cur_ff.pc),
        .out_valid (q_val),
        .out_ready (!cur_ff.pbusy),
        .out_data  (q_out)
    );

    // Outputs straight from flops
    assign serial_data_out    = cur_ff.sdo;
    assign serial_data_out_en = cur_ff.doe;
    assign prog_busy          = cur_ff.busy_o;
    assign write_enable_on    = cur_ff.wen;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Helper steps of a read
    sequence rd_start_s;
        rd_load;
    endsequence
    sequence dummy_s;
        serial_data_out == 1'b0 && serial_data_out_en;
    endsequence

    latch_set_a: assert property (en_x |=> write_enable_on)
        else $error("enable latch not set");
    latch_hold_a: assert property ($fell(write_enable_on) |-> $past(dis_x))
        else $error("enable latch cleared without disable");
    prog_gate_a: assert property (push |-> cur_ff.wen && cs_fall)
        else $error("programming without enable or deselect");
    read_dummy_a: assert property (rd_start_s |=> dummy_s)
        else $error("read dummy bit missing");
    busy_ignore_a: assert property (cur_ff.st == secp_pkg::ST_WAIT && cs_s && !cs_rise
                                    && busy && s_rise && di_s
                                    |=> cur_ff.st != secp_pkg::ST_OPC)
        else $error("start bit taken while busy");
    busy_show_a: assert property (cur_ff.st == secp_pkg::ST_WAIT && cur_ff.shown
                                  && busy && cs_s
                                  |=> !serial_data_out && serial_data_out_en)
        else $error("busy not shown");
    deselect_off_a: assert property (!cs_s |=> !serial_data_out_en)
        else $error("output driven while deselected");
    prog_time_a: assert property ($fell(cur_ff.pbusy) |-> 32'(cur_ff.blen) == PROG_CYCLES)
        else $error("programming time wrong");
    sample_rise_a: assert property (!s_rise |=> $stable(cur_ff.sh)
                                    && $stable(cur_ff.opc))
        else $error("input sampled off the rising edge");
endmodule

/* secp_core_bench.sv */
`timescale 1ns/1ps
// Self-checking bench for the serial command port
module secp_core_bench;
    logic        ref_clk, rst_n, organization_select;
    logic [1:0]  s;          // Status before and after a clocked one
    logic        chip_sel, ser_clk, serial_data_in;
    logic        serial_data_out, serial_data_out_en, prog_busy, write_enable_on;
    int          fail_count, n_checks;
    logic [7:0]  mem [128];  // Expected array
    logic [63:0] got;        // Samples of the last frame
    logic [6:0]  a;
    logic [15:0] d;
    wire         do_pin = serial_data_out_en ? serial_data_out : 1'b1; // Pull-up when released
    // Core clock, 50 MHz
    always #10 ref_clk = ~ref_clk;
    secp_core #(.PROG_CYCLES(50)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .chip_sel(chip_sel),
        .ser_clk(ser_clk), .serial_data_in(serial_data_in),
        .organization_select(organization_select), .serial_data_out(serial_data_out),
        .serial_data_out_en(serial_data_out_en), .prog_busy(prog_busy),
        .write_enable_on(write_enable_on));
    secp_host host (.chip_sel(chip_sel), .ser_clk(ser_clk), .serial_data_in(serial_data_in),
        .serial_data_out(do_pin));
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic test_done();
        if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Expected location; a word is an even/odd byte pair
    function automatic logic [15:0] exp_loc(input logic [6:0] x);
        if (!organization_select) return {8'h00, mem[x]};
        return {mem[{x[5:0], 1'b1}], mem[{x[5:0], 1'b0}]};
    endfunction
    // Model update of one location
    task automatic put(input logic [6:0] x, input logic [15:0] v);
        if (!organization_select) mem[x] = v[7:0];
        else begin
            mem[{x[5:0], 1'b0}] = v[7:0];
            mem[{x[5:0], 1'b1}] = v[15:8];
        end
    endtask
    // One instruction; the last cut bits are never sent
    task automatic run(input logic [1:0] op, input logic [6:0] x, input logic [15:0] v,
                       input int nd, input int cut);
        int          aw;
        logic [63:0] b;
        aw = organization_select ? 6 : 7;
        b = {61'h0, 1'b1, op};
        b = (b << aw) | 64'(x);
        b = (b << nd) | 64'(v);
        host.frame(3 + aw + nd - cut, b >> cut, got);
    endtask
    // Extended instruction, code in the top address bits
    task automatic ext(input logic [1:0] ex, input logic [15:0] v, input int nd);
        run(2'h0, organization_select ? {1'b0, ex, 4'h0} : {ex, 5'h0}, v, nd, 0);
    endtask
    // Bounded wait for the end of programming
    task automatic settle();
        repeat (10) @(posedge ref_clk);
        for (int i = 0; i < 300 && prog_busy !== 1'b0; i++) @(posedge ref_clk);
        if (prog_busy !== 1'b0) begin
            fail_count++;
            test_done();
        end
    endtask
    // Read one location against the model
    task automatic rd(input logic [6:0] x);
        int dw;
        dw = organization_select ? 16 : 8;
        run(2'h2, x, 16'h0, dw, 0);
        check({15'h0, got[dw]}, 16'h0);
        check(got[15:0] & (dw == 16 ? 16'hffff : 16'h00ff), exp_loc(x));
    endtask
    // Main sequence
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        organization_select = 1'b1;
        foreach (mem[i]) mem[i] = 8'hff;
        void'($urandom(32'h6c01));
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check({15'h0, write_enable_on}, 16'h0);
        run(2'h1, 7'h05, 16'h1234, 16, 0);
        check({15'h0, prog_busy}, 16'h0);
        rd(7'h05);
        ext(2'h3, 16'h0, 0);
        check({15'h0, write_enable_on}, 16'h1);
        for (int m = 1; m >= 0; m--) begin
            @(posedge ref_clk);
            organization_select <= m[0];
            @(posedge ref_clk);
            repeat (3) begin
                a = 7'($urandom) & (m == 1 ? 7'h3f : 7'h7f);
                d = 16'($urandom) & (m == 1 ? 16'hffff : 16'h00ff);
                run(2'h1, a, d, 8 + 8 * m, 0);
                host.status(s);
                check({14'h0, s}, 16'h0);
                settle();
                host.status(s);
                check({14'h0, s}, 16'h3);
                put(a, d);
                rd(a);
            end
        end
        run(2'h2, 7'h7e, 16'h0, 16, 0);
        check({15'h0, got[16]}, 16'h0);
        check(got[15:0], {mem[7'h7e], mem[7'h7f]});
        run(2'h3, a, 16'h0, 0, 0);
        settle();
        put(a, 16'hffff);
        rd(a);
        run(2'h1, a, 16'h00, 8, 1);
        repeat (20) @(posedge ref_clk);
        check({15'h0, prog_busy}, 16'h0);
        rd(a);
        @(posedge ref_clk);
        organization_select <= 1'b1;
        @(posedge ref_clk);
        d = 16'($urandom);
        ext(2'h1, d, 16);
        settle();
        for (int i = 0; i < 64; i++) put(7'(i), d);
        rd(7'($urandom) & 7'h3f);
        ext(2'h2, 16'h0, 0);
        settle();
        foreach (mem[i]) mem[i] = 8'hff;
        rd(7'h3f);
        ext(2'h0, 16'h0, 0);
        check({15'h0, write_enable_on}, 16'h0);
        run(2'h1, 7'h00, 16'h0, 16, 0);
        repeat (20) @(posedge ref_clk);
        check({15'h0, prog_busy}, 16'h0);
        rd(7'h00);
        ext(2'h3, 16'h0, 0);
        check({15'h0, write_enable_on}, 16'h1);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check({15'h0, write_enable_on}, 16'h0);
        test_done();
    end
endmodule

/* secp_host.sv */
`timescale 1ns/1ps
// Host master model; its clock stands low between frames
module secp_host (
    // Pins toward the device
    output logic      chip_sel,
    output logic      ser_clk,
    output logic      serial_data_in,
    // Device answer
    input  wire logic serial_data_out
);
    // Idle link at time zero
    initial begin
        chip_sel = 1'b0;
        ser_clk = 1'b0;
        serial_data_in = 1'b0;
    end
    // Frame of n bits, MSB first; output sampled before each rise and once after
    task automatic frame(input int n, input logic [63:0] bits, output logic [63:0] got);
        got = '0;
        #37 chip_sel = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in = bits[i];
            #80 got = {got[62:0], serial_data_out};
            ser_clk = 1'b1;
            #80 ser_clk = 1'b0;
        end
        #80 got = {got[62:0], serial_data_out};
        chip_sel = 1'b0;
        serial_data_in = ~serial_data_in;
        #200;
    endtask
    // Select, look at status, clock in a one, look again
    task automatic status(output logic [1:0] s);
        #37 chip_sel = 1'b1;
        #300 s[1] = serial_data_out;
        serial_data_in = 1'b1;
        #80 ser_clk = 1'b1;
        #80 ser_clk = 1'b0;
        #80 s[0] = serial_data_out;
        chip_sel = 1'b0;
        #200;
    endtask
endmodule

/* secp_pkg.sv */
// Functional notes
// - Organization high selects sixteen-bit words
// - Organization low selects bytes, wider address
// - Seven instructions, armed by select rising
// - Input ignored until start bit one
// - Two opcode bits follow start bit
// - Address length follows organization
// - Read emits zero dummy, then data
// - Sequential read continues without dummy bits
// - Erase and write need enable latch
// - Enable latch cleared at power-up
// - Latch held until disable or reset
// - Erase sets addressed location to ones
// - Select falling starts erase cycle
// - Busy cycle: input ignored, busy shown
// - Finished cycle: ready shown on output
// - Input sampled on serial clock rising
// - Programming starts only on select falling
// - Write erases target before programming
// - Programming timed internally, clock independent
// - Status shown whenever select high after
// - Programming lasts about ten milliseconds
// - Opcode and extended instruction encodings
// - Erase-all sets every bit to one
// - Write-all programs every location with data
// - Status held until start bit or deselect
package secp_pkg;
    localparam int BYTE_AW = 7;          // Byte address bits
    localparam int WORD_AW = 6;          // Word address bits
    localparam int MEM_BYTES = 128;      // Array size in bytes
    localparam int BYTE_DW = 8;          // Byte data bits
    localparam int WORD_DW = 16;         // Word data bits
    localparam int CLK_HZ = 50000000;    // Core clock rate
    localparam int PROG_MS = 10;         // Programming time, ms
    localparam int PROG_CYC = CLK_HZ / 1000 * PROG_MS;
    localparam int FIFO_DEPTH = 8;       // Command queue depth
    localparam logic [1:0] OP_EXT   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EX_DIS  = 2'h0;
    localparam logic [1:0] EX_WRITE_ALL_INSTR = 2'h1;
    localparam logic [1:0] EX_ERASE_ALL_INSTR = 2'h2;
    localparam logic [1:0] EX_EN   = 2'h3;
    // Kinds of programming operation
    typedef enum logic [1:0] {PK_WRITE, PK_ERASE, PK_ERASE_ALL_INSTR, PK_WRITE_ALL_INSTR} secp_pkind_t;
    // One queued programming command
    typedef struct packed {
        secp_pkind_t kind;
        logic        word;
        logic [6:0]  addr;
        logic [15:0] data;
    } secp_cmd_t;
    // Serial front-end states
    typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_OPC, ST_ADDR, ST_DATA,
                              ST_READ, ST_HOLD} secp_st_t;
endpackage
